/* rtl/mlt_phy_latency.sv */
// Latency timing core for the PHY side of a nibble MII in three line modes
`include "mlt_params.svh"
module mlt_phy_latency (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Line mode select pins
    input  wire logic [1:0] mode_sel,
    // Link clock and transmit side from the MAC
    input  wire logic       mii_clk,
    input  wire logic       tx_en,
    input  wire logic       tx_er,
    input  wire logic [3:0] txd,
    // Receive and status side toward the MAC
    output wire logic       crs,
    output wire logic       col,
    output wire logic       rx_dv,
    output wire logic       rx_er,
    output wire logic [3:0] rxd,
    // Line receive side
    input  wire logic       line_rx_input,
    input  wire logic       line_rx_err,
    input  wire logic [3:0] line_rx_data,
    // Line transmit side
    output wire logic       line_tx_output,
    output wire logic       line_tx_err,
    output wire logic [3:0] line_tx_data
);
    // Delay stage indices
    localparam int D_RXCRS = 0;
    localparam int D_DV    = 1;
    localparam int D_COL   = 2;
    localparam int D_TXCRS = 3;
    localparam int D_LTX   = 4;
    localparam int N_DLY   = 5;
    localparam int SYNC_W  = 15;

    // Pin synchroniser stages and accepted values
    logic [SYNC_W-1:0] s1_reg;
    logic [SYNC_W-1:0] s2_reg;
    logic [SYNC_W-1:0] s3_reg;
    logic [SYNC_W-1:0] acc_reg;
    logic [SYNC_W-1:0] acc_next;
    logic [1:0]        f_mode;
    logic              f_mclk;
    logic              f_tx_en;
    logic              f_tx_er;
    logic [3:0]        f_txd;
    logic              rx_act;
    logic              f_rx_err;
    logic [3:0]        f_rx_data;

    // Link clock edges and sampled transmit side
    logic       mclk_prev_reg;
    logic       mclk_rise;
    logic       mclk_fall;
    logic       tx_act_reg;
    logic       tx_err_reg;
    logic [3:0] txd_reg;

    // Mode state
    mlt_pkg::mlt_mode_type mode_reg;
    mlt_pkg::mlt_mode_type mode_next;
    logic                  idle;

    // Delay stage plumbing
    logic [N_DLY-1:0]     dly_in;
    logic [N_DLY-1:0]     dly_out;
    mlt_pkg::mlt_cnt_type rise_sel [N_DLY];
    mlt_pkg::mlt_cnt_type fall_sel [N_DLY];

    // Output registers
    logic       crs_reg;
    logic       col_reg;
    logic       rx_dv_reg;
    logic       rx_er_reg;
    logic [3:0] rxd_reg;
    logic       line_tx_output_reg;
    logic       line_tx_err_reg;
    logic [3:0] line_tx_data_reg;

    // Three-stage synchroniser; only the second stage reads the first
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= {mode_sel, mii_clk, tx_en, tx_er, txd,
                       line_rx_input, line_rx_err, line_rx_data};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A bit changes once stages two and three agree
    always_comb begin
        acc_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (acc_reg & (s2_reg ^ s3_reg));
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            acc_reg <= '0;
        end else begin
            acc_reg <= acc_next;
        end
    end

    assign {f_mode, f_mclk, f_tx_en, f_tx_er, f_txd, rx_act, f_rx_err, f_rx_data} = acc_reg;

    // Link clock edge finder
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mclk_prev_reg <= 1'b0;
        end else begin
            mclk_prev_reg <= f_mclk;
        end
    end

    assign mclk_rise = f_mclk & ~mclk_prev_reg;
    assign mclk_fall = ~f_mclk & mclk_prev_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_act_reg <= 1'b0;
            tx_err_reg <= 1'b0;
            txd_reg    <= 4'h0;
        end else if (mclk_rise) begin
            tx_act_reg <= f_tx_en;
            tx_err_reg <= f_tx_er;
            txd_reg    <= f_txd;
        end
    end

    // Mode only moves between frames so no delay set is mixed mid-frame
    assign idle = ~rx_act & ~tx_act_reg;

    always_comb begin
        case (f_mode)
            `MLT_SEL_TP100: mode_next = mlt_pkg::MLT_TP100;
            `MLT_SEL_FX100: mode_next = mlt_pkg::MLT_FX100;
            `MLT_SEL_TP10:  mode_next = mlt_pkg::MLT_TP10;
            default:        mode_next = mode_reg;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_reg <= mlt_pkg::MLT_TP100;
        end else if (idle) begin
            mode_reg <= mode_next;
        end
    end

    function automatic mlt_pkg::mlt_cnt_type pick(input mlt_pkg::mlt_mode_type m,
                                                  input int tp, input int fx, input int t10);
        case (m)
            mlt_pkg::MLT_TP100: return mlt_pkg::to_cycles(tp, `MLT_BT_NS_FAST);
            mlt_pkg::MLT_FX100: return mlt_pkg::to_cycles(fx, `MLT_BT_NS_FAST);
            mlt_pkg::MLT_TP10:  return mlt_pkg::to_cycles(t10, `MLT_BT_NS_SLOW);
            default:            return mlt_pkg::to_cycles(tp, `MLT_BT_NS_FAST);
        endcase
    endfunction : pick

    // Delay counts for every stage from the current mode
    always_comb begin
        rise_sel[D_RXCRS] = pick(mode_reg, `MLT_CRS_RX_ON_TP, `MLT_CRS_RX_ON_FX,
                                 `MLT_CRS_RX_ON_10);
        // carrier off after T or quiet
        fall_sel[D_RXCRS] = pick(mode_reg, `MLT_CRS_RX_OFF_TP, `MLT_CRS_RX_OFF_FX,
                                 `MLT_CRS_RX_OFF_10);
        rise_sel[D_DV]    = pick(mode_reg, `MLT_DV_ON_TP, `MLT_DV_ON_FX, `MLT_DV_ON_10);
        fall_sel[D_DV]    = pick(mode_reg, `MLT_DV_OFF_TP, `MLT_DV_OFF_FX, `MLT_DV_OFF_10);
        rise_sel[D_COL]   = pick(mode_reg, `MLT_COL_ON_TP, `MLT_COL_ON_FX, `MLT_COL_ON_10);
        fall_sel[D_COL]   = pick(mode_reg, `MLT_COL_OFF_TP, `MLT_COL_OFF_FX,
                                 `MLT_COL_OFF_10);
        rise_sel[D_TXCRS] = pick(mode_reg, `MLT_CRS_TX_ON_TP, `MLT_CRS_TX_ON_FX,
                                 `MLT_CRS_TX_ON_10);
        fall_sel[D_TXCRS] = pick(mode_reg, `MLT_CRS_TX_OFF_TP, `MLT_CRS_TX_OFF_FX,
                                 `MLT_CRS_TX_OFF_10);
        rise_sel[D_LTX]   = pick(mode_reg, `MLT_LTX_LAT_TP, `MLT_LTX_LAT_FX,
                                 `MLT_LTX_LAT_10);
        fall_sel[D_LTX]   = rise_sel[D_LTX];
    end

    // Stage inputs: receive activity, collision and transmit enable
    always_comb begin
        dly_in          = '0;
        dly_in[D_RXCRS] = rx_act;
        dly_in[D_DV]    = rx_act;
        dly_in[D_COL]   = rx_act & tx_act_reg;
        dly_in[D_TXCRS] = tx_act_reg;
        dly_in[D_LTX]   = tx_act_reg;
    end

    // One delay stage per timed signal
    for (genvar g = 0; g < N_DLY; g++) begin : g_dly
        mlt_dly_if dly_if ();
        assign dly_if.level_in = dly_in[g];
        assign dly_if.rise_cnt = rise_sel[g];
        assign dly_if.fall_cnt = fall_sel[g];
        assign dly_out[g]      = dly_if.level_out;
        mlt_level_delay u_dly (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .dly      (dly_if.delay)
        );
    end

    // carrier is receive, transmit or valid still up
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            crs_reg <= 1'b0;
        end else begin
            // Holding on valid keeps carrier from dropping ahead of it
            crs_reg <= dly_out[D_RXCRS] | dly_out[D_TXCRS] | rx_dv_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            col_reg <= 1'b0;
        end else begin
            col_reg <= dly_out[D_COL];
        end
    end

    // launch on fall, stable at rise
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_dv_reg <= 1'b0;
            rx_er_reg <= 1'b0;
            rxd_reg   <= 4'h0;
        end else if (mclk_fall) begin
            rx_dv_reg <= dly_out[D_DV] & crs_reg;
            rx_er_reg <= dly_out[D_DV] & crs_reg & f_rx_err;
            rxd_reg   <= (dly_out[D_DV] & crs_reg) ? f_rx_data : 4'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            line_tx_output_reg <= 1'b0;
            line_tx_err_reg    <= 1'b0;
            line_tx_data_reg   <= 4'h0;
        end else begin
            line_tx_output_reg <= dly_out[D_LTX];
            line_tx_err_reg    <= dly_out[D_LTX] & tx_err_reg;
            line_tx_data_reg   <= dly_out[D_LTX] ? txd_reg : 4'h0;
        end
    end

    assign crs            = crs_reg;
    assign col            = col_reg;
    assign rx_dv          = rx_dv_reg;
    assign rx_er          = rx_er_reg;
    assign rxd            = rxd_reg;
    assign line_tx_output = line_tx_output_reg;
    assign line_tx_err    = line_tx_err_reg;
    assign line_tx_data   = line_tx_data_reg;

    // Checks on the timed outputs, transmit enable sampling and mode changes
    logic is_10;
    logic is_tp;
    assign is_10 = (mode_reg == mlt_pkg::MLT_TP10);
    assign is_tp = (mode_reg == mlt_pkg::MLT_TP100);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_rx_start_10;
        $rose(rx_act) && is_10 ##1 rx_act [*5];
    endsequence
    sequence s_tx_start_tp;
        $rose(tx_act_reg) && is_tp ##1 tx_act_reg [*5];
    endsequence

    property p_crs_on_10;
        s_rx_start_10 |-> crs_reg;
    endproperty
    a_crs_on_10: assert property (p_crs_on_10)
        else $error("carrier late after line activity at 10M");

    property p_crs_on_tp;
        $rose(rx_act) && is_tp ##1 rx_act [*5] |-> crs_reg;
    endproperty
    a_crs_on_tp: assert property (p_crs_on_tp)
        else $error("carrier late after J on twisted pair");

    property p_dv_after_crs;
        $rose(rx_dv_reg) |-> $past(crs_reg);
    endproperty
    a_dv_after_crs: assert property (p_dv_after_crs)
        else $error("receive valid rose without carrier");

    property p_crs_after_dv;
        $fell(crs_reg) |-> !$past(rx_dv_reg);
    endproperty
    a_crs_after_dv: assert property (p_crs_after_dv)
        else $error("carrier dropped before receive valid");

    property p_col_on_10;
        $rose(dly_in[D_COL]) && is_10 ##1 dly_in[D_COL] [*4] |-> col_reg;
    endproperty
    a_col_on_10: assert property (p_col_on_10)
        else $error("collision late at 10M");

    property p_col_off_10;
        $fell(dly_in[D_COL]) && is_10 ##1 !dly_in[D_COL] [*8] |-> !col_reg;
    endproperty
    a_col_off_10: assert property (p_col_off_10)
        else $error("collision held too long at 10M");

    property p_txcrs_on_tp;
        s_tx_start_tp |-> crs_reg;
    endproperty
    a_txcrs_on_tp: assert property (p_txcrs_on_tp)
        else $error("transmit carrier late on twisted pair");

    property p_txcrs_off_10;
        $fell(tx_act_reg) && is_10 ##1 !tx_act_reg [*3] |-> !dly_out[D_TXCRS];
    endproperty
    a_txcrs_off_10: assert property (p_txcrs_off_10)
        else $error("transmit carrier held too long at 10M");

    property p_ltx_lat_10;
        $rose(tx_act_reg) && is_10 && !dly_out[D_LTX] |-> !line_tx_output_reg [*8];
    endproperty
    a_ltx_lat_10: assert property (p_ltx_lat_10)
        else $error("line output too early at 10M");

    property p_tx_sample;
        $changed(tx_act_reg) |-> $past(mclk_rise);
    endproperty
    a_tx_sample: assert property (p_tx_sample)
        else $error("transmit enable taken off a link clock rise");

    property p_rx_launch;
        $changed(rx_dv_reg) |-> $past(mclk_fall);
    endproperty
    a_rx_launch: assert property (p_rx_launch)
        else $error("receive valid moved off a link clock fall");

    property p_mode_idle;
        $changed(mode_reg) |-> $past(idle);
    endproperty
    a_mode_idle: assert property (p_mode_idle)
        else $error("line mode changed during a frame");
endmodule : mlt_phy_latency

/* rtl/mlt_params.svh */
// Timing and encoding constants for the MII latency core
`ifndef MLT_PARAMS_SVH
`define MLT_PARAMS_SVH
// Core clock period and bit times in ns
`define MLT_CLK_NS          100
`define MLT_BT_NS_FAST      10
`define MLT_BT_NS_SLOW      100
// Delays are held in tenths of a bit time
`define MLT_TENTHS          10
`define MLT_CNT_W           8
// Line mode select pin codes
`define MLT_SEL_TP100       2'h0
`define MLT_SEL_FX100       2'h1
`define MLT_SEL_TP10        2'h2
// Receive carrier on/off after line start/end (TP, FX, 10M)
`define MLT_CRS_RX_ON_TP    120
`define MLT_CRS_RX_ON_FX    120
`define MLT_CRS_RX_ON_10    20
`define MLT_CRS_RX_OFF_TP   100
`define MLT_CRS_RX_OFF_FX   160
`define MLT_CRS_RX_OFF_10   63
// Receive data valid on/off
`define MLT_DV_ON_TP        150
`define MLT_DV_ON_FX        150
`define MLT_DV_ON_10        70
`define MLT_DV_OFF_TP       100
`define MLT_DV_OFF_FX       160
`define MLT_DV_OFF_10       60
// Collision on/off
`define MLT_COL_ON_TP       160
`define MLT_COL_ON_FX       100
`define MLT_COL_ON_10       10
`define MLT_COL_OFF_TP      170
`define MLT_COL_OFF_FX      140
`define MLT_COL_OFF_10      50
// Transmit carrier on/off after enable sampled
`define MLT_CRS_TX_ON_TP    200
`define MLT_CRS_TX_ON_FX    170
`define MLT_CRS_TX_ON_10    20
`define MLT_CRS_TX_OFF_TP   240
`define MLT_CRS_TX_OFF_FX   220
`define MLT_CRS_TX_OFF_10   10
// Transmit latency to line output
`define MLT_LTX_LAT_TP      53
`define MLT_LTX_LAT_FX      50
`define MLT_LTX_LAT_10      725
`endif

/* rtl/mlt_pkg.sv */
// Types and delay conversion for the MII latency core
`include "mlt_params.svh"
package mlt_pkg;
    typedef enum logic [2:0] {
        MLT_TP100 = 3'h1,
        MLT_FX100 = 3'h2,
        MLT_TP10  = 3'h4
    } mlt_mode_type;

    typedef logic [`MLT_CNT_W-1:0] mlt_cnt_type;

    // Tenths of a bit time to core cycles, rounded up, never below one
    function automatic mlt_cnt_type to_cycles(input int tenths, input int bt_ns);
        int c;
        c = (tenths * bt_ns + `MLT_TENTHS * `MLT_CLK_NS - 1) / (`MLT_TENTHS * `MLT_CLK_NS);
        if (c < 1) begin
            c = 1;
        end
        return mlt_cnt_type'(c);
    endfunction : to_cycles
endpackage : mlt_pkg

/* rtl/mlt_dly_if.sv */
// Level and delay counts between the core and one delay stage
interface mlt_dly_if;
    logic               level_in;
    logic               level_out;
    mlt_pkg::mlt_cnt_type rise_cnt;
    mlt_pkg::mlt_cnt_type fall_cnt;
    modport delay (input level_in, input rise_cnt, input fall_cnt, output level_out);
    modport user  (output level_in, output rise_cnt, output fall_cnt, input level_out);
endinterface : mlt_dly_if

/* rtl/mlt_level_delay.sv */
// Level delay stage with separate rise and fall cycle counts
module mlt_level_delay (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Level in, delayed level out
    mlt_dly_if.delay dly
);
    localparam int W = $bits(mlt_pkg::mlt_cnt_type);

    logic         pend_reg;
    logic [W-1:0] cnt_reg;
    logic         out_reg;

    assign dly.level_out = out_reg;

    // A new level restarts the count; a glitch shorter than the delay is dropped
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pend_reg <= 1'b0;
            cnt_reg  <= '0;
        end else if (dly.level_in != pend_reg) begin
            pend_reg <= dly.level_in;
            cnt_reg  <= dly.level_in ? W'(dly.rise_cnt - 1'b1) : W'(dly.fall_cnt - 1'b1);
        end else if (cnt_reg != '0) begin
            cnt_reg <= W'(cnt_reg - 1'b1);
        end
    end

    // Output follows only once the level held for the whole count
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            out_reg <= 1'b0;
        end else if (pend_reg == dly.level_in && cnt_reg == '0) begin
            out_reg <= pend_reg;
        end
    end

    property p_out_on_expiry;
        @(posedge core_clk) disable iff (!rst_n)
        $changed(out_reg) |-> $past(cnt_reg == '0 && pend_reg == dly.level_in);
    endproperty
    a_out_on_expiry: assert property (p_out_on_expiry)
        else $error("delay output moved before its count expired");
endmodule : mlt_level_delay

/* tb/mlt_mac_model.sv */
// Behavioural MAC on the far side of the MII latency core
module mlt_mac_model (
    // Core clock, used to place pin changes off its sampling edge
    input  wire logic       core_clk,
    // Link clock and transmit side toward the device
    output logic            mii_clk,
    output logic            tx_en,
    output logic            tx_er,
    output logic [3:0]      txd,
    // Receive side from the device
    input  wire logic       rx_dv,
    input  wire logic [3:0] rxd,
    // Capture record for the bench
    output logic [3:0]      rx_last,
    output int              rx_cnt
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        mii_clk = 1'b0;
        tx_en   = 1'b0;
        tx_er   = 1'b0;
        txd     = 4'h0;
        rx_last = 4'h0;
        rx_cnt  = 0;
        // Odd start offset keeps every link clock edge 20 ns ahead of a core clock rise
        #130;
        forever begin
            #400 mii_clk = ~mii_clk;
        end
    end

    always @(posedge mii_clk) begin
        if (rx_dv === 1'b1) begin
            rx_last <= rxd;
            rx_cnt  <= rx_cnt + 1;
        end
    end

    task automatic tx_set(input logic en, input logic er, input logic [3:0] nib);
        @(negedge mii_clk);
        @(negedge core_clk);
        tx_en = en;
        tx_er = er;
        // Idle data is inverted so a stale nibble never looks valid
        txd   = en ? nib : ~nib;
    endtask : tx_set
endmodule : mlt_mac_model

/* tb/mlt_phy_latency_tb_top.sv */
// Self-checking bench for the MII latency core in all three line modes
module mlt_phy_latency_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // Pin sync plus wait for the link clock edge, in core cycles
    localparam int SLACK = 12;
    localparam int LIMIT = 400;
    // Windows in core cycles per mode: twisted pair, fibre, 10M
    localparam int CRS_ON_LO [3] = '{0, 0, 2};
    localparam int CRS_ON_HI [3] = '{2, 2, 28};
    localparam int DV_LO [3] = '{0, 0, 5};
    localparam int DV_HI [3] = '{1, 1, 32};
    localparam int CRS_OFF_LO [3] = '{0, 0, 6};
    localparam int CRS_OFF_HI [3] = '{2, 3, 10};
    localparam int COL_ON_LO [3] = '{0, 0, 1};
    localparam int COL_ON_HI [3] = '{3, 2, 31};
    localparam int COL_OFF_LO [3] = '{0, 0, 5};
    localparam int COL_OFF_HI [3] = '{2, 2, 10};
    localparam int TXC_ON_HI [3] = '{3, 2, 2};
    localparam int TXC_OFF_HI [3] = '{3, 3, 1};
    localparam int LTX_LO [3] = '{0, 0, 72};
    localparam int LTX_HI [3] = '{1, 1, 73};

    logic       core_clk;
    logic       rst_n;
    logic [1:0] mode_sel;
    logic       mii_clk;
    logic       tx_en;
    logic       tx_er;
    logic [3:0] txd;
    logic       crs;
    logic       col;
    logic       rx_dv;
    logic       rx_er;
    logic [3:0] rxd;
    logic       line_rx_input;
    logic       line_rx_err;
    logic [3:0] line_rx_data;
    logic       line_tx_output;
    logic       line_tx_err;
    logic [3:0] line_tx_data;
    logic [3:0] rx_last;
    int         rx_cnt;
    int         n_fail;
    int         num_checks;

    mlt_phy_latency dut (
        .core_clk(core_clk), .rst_n(rst_n), .mode_sel(mode_sel), .mii_clk(mii_clk),
        .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .crs(crs), .col(col),
        .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .line_rx_input(line_rx_input),
        .line_rx_err(line_rx_err), .line_rx_data(line_rx_data),
        .line_tx_output(line_tx_output), .line_tx_err(line_tx_err),
        .line_tx_data(line_tx_data)
    );

    mlt_mac_model mac (
        .core_clk(core_clk), .mii_clk(mii_clk), .tx_en(tx_en), .tx_er(tx_er), .txd(txd),
        .rx_dv(rx_dv), .rxd(rxd), .rx_last(rx_last), .rx_cnt(rx_cnt)
    );

    // Core clock, 100 ns period
    always #50 core_clk = ~core_clk;

    function automatic logic sig(input int s);
        case (s)
            0: return crs;
            1: return col;
            2: return rx_dv;
            default: return line_tx_output;
        endcase
    endfunction : sig

    // Count settled cycles until a status output or the line output reaches a level
    task automatic wait_for(input int s, input logic v, output int n);
        n = 0;
        while (sig(s) !== v && n < LIMIT) begin
            @(negedge core_clk);
            n++;
        end
    endtask : wait_for

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic rng(input int n, input int lo, input int hi, input string msg);
        check(n >= lo && n <= hi + SLACK, msg);
    endtask : rng

    task automatic summarize;
        $display("checks %0d, failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize

    // Mode pins only take effect while idle, so settle before traffic
    task automatic set_mode(input int m);
        @(negedge core_clk);
        mode_sel = 2'(m);
        repeat (10) @(negedge core_clk);
    endtask : set_mode

    task automatic test_reset;
        @(negedge core_clk);
        check({crs, col, rx_dv, rx_er, line_tx_output, rxd, line_tx_data} === 13'h0,
              "outputs not quiet after reset");
    endtask : test_reset

    task automatic test_rx(input int m);
        int a;
        int b;
        int c;
        int d;
        line_rx_data  = 4'ha ^ 4'(m);
        line_rx_err   = (m == 1);
        line_rx_input = 1'b1;
        fork
            wait_for(0, 1'b1, a);
            wait_for(2, 1'b1, b);
        join
        rng(a, CRS_ON_LO[m], CRS_ON_HI[m], "carrier rise after line start");
        rng(b - a, DV_LO[m], DV_HI[m], "valid not after carrier");
        check(rxd === line_rx_data && rx_er === line_rx_err, "receive nibble");
        repeat (2) @(posedge mii_clk);
        @(negedge core_clk);
        check(rx_last === line_rx_data && rx_cnt > 0, "nibble at link rise");
        check(col === 1'b0, "collision without transmit");
        line_rx_input = 1'b0;
        fork
            wait_for(0, 1'b0, c);
            wait_for(2, 1'b0, d);
        join
        rng(c, CRS_OFF_LO[m], CRS_OFF_HI[m], "carrier drop after line end");
        if (m == 2) begin
            check(c == d + 1, "carrier not just after valid");
        end
        repeat (20) @(negedge core_clk);
    endtask : test_rx

    task automatic test_tx(input int m);
        int a;
        int b;
        int c;
        int d;
        mac.tx_set(1'b1, m == 2, 4'h5 + 4'(m));
        fork
            wait_for(0, 1'b1, a);
            wait_for(3, 1'b1, b);
        join
        rng(a, 0, TXC_ON_HI[m], "transmit carrier rise");
        rng(b, LTX_LO[m], LTX_HI[m], "line output latency");
        check(line_tx_data === txd && line_tx_err === tx_er, "line nibble");
        mac.tx_set(1'b0, 1'b0, txd);
        fork
            wait_for(0, 1'b0, c);
            wait_for(3, 1'b0, d);
        join
        rng(c, 0, TXC_OFF_HI[m], "transmit carrier drop");
        rng(d, LTX_LO[m], LTX_HI[m], "line output end");
        repeat (20) @(negedge core_clk);
    endtask : test_tx

    task automatic test_col(input int m);
        int a;
        int b;
        mac.tx_set(1'b1, 1'b0, 4'h3);
        repeat (12) @(negedge core_clk);
        line_rx_input = 1'b1;
        wait_for(1, 1'b1, a);
        rng(a, COL_ON_LO[m], COL_ON_HI[m], "collision rise");
        line_rx_input = 1'b0;
        wait_for(1, 1'b0, b);
        rng(b, COL_OFF_LO[m], COL_OFF_HI[m], "collision drop");
        mac.tx_set(1'b0, 1'b0, 4'h3);
        wait_for(3, 1'b0, a);
        wait_for(0, 1'b0, b);
        repeat (20) @(negedge core_clk);
    endtask : test_col

    // Watchdog, far beyond the several hundred cycles the tests need
    initial begin
        #2000000;
        n_fail++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        summarize();
    end

    // Main sequence
    initial begin
        core_clk      = 1'b0;
        rst_n         = 1'b0;
        mode_sel      = 2'h0;
        line_rx_input = 1'b0;
        line_rx_err   = 1'b0;
        line_rx_data  = 4'h0;
        n_fail        = 0;
        num_checks    = 0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        test_reset();
        for (int m = 0; m < 3; m++) begin
            set_mode(m);
            test_rx(m);
            test_tx(m);
            test_col(m);
        end
        summarize();
    end
endmodule : mlt_phy_latency_tb_top
